// ===== hdl/cpu_interrupt_flag_control.sv
// Purpose: Interrupt enable, stack-select and priority level flag logic.
// Assumes: Request and acknowledge inputs are synchronous to core_clk.
// Notes:   Software sees the flags over APB; the sequencer acknowledges.
`timescale 1ns/100ps

module cpu_interrupt_flag_control
	import flag_ctl_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire irq_req_t    irqReq,
	input  wire logic        irqAck,
	output logic             irqAccept,
	output logic             useUserStack
);

	// ==========================================================
	// Bus decode
	logic              enable_q;
	logic              stackSel_q;
	logic [PRIO_W-1:0] processor_priority_level_q;
	logic              accepted_q;
	logic              acceptSticky_q;
	logic              acceptSticky_d;
	logic              enable_d;
	logic              stackSel_d;
	logic [PRIO_W-1:0] prio_d;
	logic [31:0]       prdata_d;

	wire busWrite  = psel && penable && pwrite;
	wire busRead   = psel && !pwrite;
	wire hitFlag   = (paddr == FLAG_OFS);
	wire hitStatus = (paddr == STATUS_OFS);
	wire hitTrap   = (paddr == TRAP_OFS);
	wire hitAny    = hitFlag || hitStatus || hitTrap;
	wire flagWr    = busWrite && hitFlag;
	// A trap write stands for a software interrupt instruction.
	wire trapWr    = busWrite && hitTrap;
	wire trapLow   = trapWr && (pwdata[TRAP_W-1:0] < TRAP_W'(SW_VEC_LIMIT));

	// ==========================================================
	// Acceptance
	// strict priority compare
	wire prioAbove = irqReq.prio > processor_priority_level_q;
	wire acceptNow = irqReq.valid && enable_q && prioAbove;
	assign irqAccept = acceptNow;
	assign useUserStack = stackSel_q;

	// ==========================================================
	// Flag next state
	always_comb
	begin
		enable_d   = enable_q;
		stackSel_d = stackSel_q;
		prio_d     = processor_priority_level_q;
		if (flagWr)
		begin
			enable_d   = pwdata[ENABLE_BIT];
			stackSel_d = pwdata[STACK_SEL_BIT];
			prio_d     = pwdata[PRIO_LSB +: PRIO_W];
		end
		// Hardware events win over a software write in the same cycle.
		if (irqAck)
		begin
			enable_d = 1'b0;
		end
		if ((irqAck && irqReq.hardware) || trapLow)
		begin
			stackSel_d = 1'b0;
		end
	end

	// Accept-seen status is sticky; set wins over a clear by write.
	assign acceptSticky_d = acceptNow ? 1'b1 :
		((busWrite && hitStatus) ? 1'b0 : acceptSticky_q);

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enable_q                   <= ENABLE_RST;
			stackSel_q                 <= STACK_SEL_RST;
			processor_priority_level_q <= PRIO_RST;
			acceptSticky_q             <= 1'b0;
			accepted_q                 <= 1'b0;
		end
		else
		begin
			enable_q                   <= enable_d;
			stackSel_q                 <= stackSel_d;
			processor_priority_level_q <= prio_d;
			acceptSticky_q             <= acceptSticky_d;
			accepted_q                 <= acceptNow;
		end
	end

	// ==========================================================
	// Read path
	flags_t curFlags;
	assign curFlags = '{enable: enable_q, stackSel: stackSel_q,
		prio: processor_priority_level_q};

	// The reserved bit reads as zero, a legal choice for undefined.
	always_comb
	begin
		prdata_d = RSVD_READ;
		if (hitFlag)
		begin
			prdata_d[ENABLE_BIT]          = curFlags.enable;
			prdata_d[STACK_SEL_BIT]       = curFlags.stackSel;
			prdata_d[PRIO_LSB +: PRIO_W]  = curFlags.prio;
		end
		else if (hitStatus)
		begin
			prdata_d[STS_STICKY_BIT] = acceptSticky_q;
			prdata_d[STS_LAST_BIT]   = accepted_q;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			prdata <= RSVD_READ;
		else if (busRead && !penable)
			prdata <= prdata_d;
	end

	// One wait-free access: data is latched in setup, ready in access.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hitAny;

	// ==========================================================
	// Checks
	gate_enable_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		!enable_q |-> !irqAccept)
		else $error("accept while enable flag clear");

	ack_clear_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		irqAck |=> !enable_q)
		else $error("enable flag not cleared by acknowledge");

	ack_block_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		irqAck |=> !irqAccept)
		else $error("accept right after acknowledge");

	stack_pick_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		useUserStack == stackSel_q)
		else $error("stack selection mismatch");

	stack_write_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(flagWr && !(irqAck && irqReq.hardware)) |=>
		useUserStack == $past(pwdata[STACK_SEL_BIT]))
		else $error("stack select write lost");

	hw_stack_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(irqAck && irqReq.hardware) |=> !useUserStack)
		else $error("stack select not cleared by hardware ack");

	trap_stack_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		trapLow |=> !useUserStack)
		else $error("stack select not cleared by low trap");

	trap_high_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(trapWr && !trapLow && !irqAck) |=> $stable(useUserStack))
		else $error("high trap vector changed stack select");

	// A hardware acknowledge must drop both flags at the very next edge.
	sequence hwAckSeq;
		irqAck && irqReq.hardware;
	endsequence

	sequence flagsClearSeq;
		!enable_q && !useUserStack;
	endsequence

	hw_ack_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		hwAckSeq |=> flagsClearSeq)
		else $error("hardware ack left a flag set");

	level_write_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(flagWr && !irqAck) |=> processor_priority_level_q
		== $past(pwdata[PRIO_LSB +: PRIO_W]))
		else $error("priority level write lost");

	prio_strict_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		irqAccept |-> irqReq.prio > processor_priority_level_q)
		else $error("accept without higher priority");

	prio_equal_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(irqReq.valid && irqReq.prio == processor_priority_level_q)
		|-> !irqAccept)
		else $error("accept at equal priority");

	accept_full_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(irqReq.valid && enable_q && prioAbove) |-> irqAccept
		##1 acceptSticky_q)
		else $error("qualified request not accepted");

	sticky_win_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(acceptNow && busWrite && hitStatus) |=> acceptSticky_q)
		else $error("accept lost to status clear");

	rsvd_read_a: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(busRead && !penable && hitFlag) |=> !prdata[RSVD_BIT])
		else $error("reserved bit read nonzero");

endmodule : cpu_interrupt_flag_control

// ===== hdl/flag_ctl_pkg.sv
// Purpose: Shared constants and types for the processor flag control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package flag_ctl_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] FLAG_OFS     = 8'h00;
	localparam logic [7:0] STATUS_OFS   = 8'h04;
	localparam logic [7:0] TRAP_OFS     = 8'h08;

	// ==========================================================
	// Field layout of the flag, trap and status registers
	localparam int ENABLE_BIT    = 0;
	localparam int STACK_SEL_BIT = 1;
	localparam int RSVD_BIT      = 2;
	localparam int PRIO_LSB      = 4;
	localparam int PRIO_W        = 3;
	localparam int TRAP_W        = 6;
	localparam int SW_VEC_LIMIT  = 32;
	localparam int STS_STICKY_BIT = 0;
	localparam int STS_LAST_BIT   = 1;

	localparam logic              ENABLE_RST    = 1'b0;
	localparam logic              STACK_SEL_RST = 1'b0;
	localparam logic [PRIO_W-1:0] PRIO_RST      = 3'h0;
	localparam logic [31:0]       RSVD_READ     = 32'h0;

	typedef struct packed
	{
		logic              valid;
		logic [PRIO_W-1:0] prio;
		logic              hardware;
	} irq_req_t;

	typedef struct packed
	{
		logic              enable;
		logic              stackSel;
		logic [PRIO_W-1:0] prio;
	} flags_t;

endpackage : flag_ctl_pkg

// ===== dv/irq_source_model.sv
// Purpose: Interrupt source and sequencer stand-in for the flag block.
// Assumes: Requests and acknowledges change just after a rising edge.
// Notes:   The acknowledge is only raised while a request is valid.
`timescale 1ns/100ps

module irq_source_model
	import flag_ctl_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     nrst,
	input  wire irq_req_t want,
	input  wire logic     ackGo,
	output irq_req_t      irqReq,
	output logic          irqAck
);
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			irqReq <= '0;
			irqAck <= 1'b0;
		end
		else
		begin
			irqReq <= want;
			irqAck <= ackGo & want.valid;
		end
endmodule : irq_source_model

// ===== dv/tb.sv
// Purpose: Self-checking bench for the flag control block.
// Assumes: Zero-wait APB slave; reads are checked by a monitor queue.
// Notes:   Level is random; acceptance is swept over all priorities.
`timescale 1ns/100ps
`define CHK(N, E, S) begin compares++; if ((S) !== (E)) begin \
	nMismatch++; $display("ERROR %s exp %h got %h", N, E, S); end end

module tb
	import flag_ctl_pkg::*;
;
	logic        core_clk = 0, nrst = 0, psel = 0, penable = 0;
	logic        pwrite = 0, ackGo = 0, pready, pslverr;
	logic        irqAccept, useUserStack, irqAck;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [32:0] expQ[$], head;
	logic [2:0]  lvl;
	irq_req_t    irqReq, want = '0;
	int          nMismatch = 0, compares = 0, seed = 96442;

	cpu_interrupt_flag_control cpu_interrupt_flag_control_i (.core_clk(core_clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irqReq(irqReq), .irqAck(irqAck),
		.irqAccept(irqAccept), .useUserStack(useUserStack));
	irq_source_model irq_source_model_i (.core_clk(core_clk), .nrst(nrst),
		.want(want), .ackGo(ackGo), .irqReq(irqReq), .irqAck(irqAck));

	always #2.5 core_clk = ~core_clk;

	function automatic logic [31:0] fw(logic en, logic ss, logic [2:0] l);
		return (32'(l) << PRIO_LSB) | (32'(ss) << STACK_SEL_BIT) | 32'(en);
	endfunction : fw

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic rd(logic [7:0] a, logic [31:0] e);
		expQ.push_back({a != FLAG_OFS && a != STATUS_OFS && a != TRAP_OFS, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Read results are compared as the access phase completes.
	always @(posedge core_clk)
	begin
		if (psel && penable)
			`CHK("pready", 1'b1, pready)
		if (psel && penable && pready && !pwrite)
		begin
			head = expQ.pop_front();
			`CHK("prdata", head, {pslverr, prdata})
		end
	end

	task automatic ack(logic hw);
		@(posedge core_clk)
		begin
			want  <= '{1'b1, 3'h7, hw};
			ackGo <= 1'b1;
		end
		@(posedge core_clk) ackGo <= 1'b0;
		@(posedge core_clk) want <= '0;
	endtask : ack

	task automatic wrap_up;
		$display("compares %0d nMismatch %0d", compares, nMismatch);
		if (nMismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	initial
	begin
		#20000;
		nMismatch++;
		wrap_up();
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		rd(FLAG_OFS, 32'h0);
		lvl = 3'($random(seed));
		apb(1'b1, FLAG_OFS, fw(1'b1, 1'b1, lvl));
		rd(FLAG_OFS, fw(1'b1, 1'b1, lvl));
		`CHK("useUserStack", 1'b1, useUserStack)
		$display("test flags done");
		for (int en = 0; en < 2; en++)
		begin
			apb(1'b1, FLAG_OFS, fw(en[0], 1'b1, lvl));
			for (int p = 0; p < 8; p++)
			begin
				@(posedge core_clk) want <= '{1'b1, 3'(p), 1'b0};
				@(posedge core_clk) #1;
				`CHK("irqAccept", en == 1 && p > lvl, irqAccept)
			end
		end
		$display("test accept done");
		ack(1'b1);
		rd(FLAG_OFS, fw(1'b0, 1'b0, lvl));
		`CHK("useUserStack", 1'b0, useUserStack)
		apb(1'b1, FLAG_OFS, fw(1'b1, 1'b1, lvl));
		ack(1'b0);
		rd(FLAG_OFS, fw(1'b0, 1'b1, lvl));
		$display("test ack done");
		apb(1'b1, FLAG_OFS, fw(1'b0, 1'b1, lvl));
		apb(1'b1, TRAP_OFS, 32'(SW_VEC_LIMIT));
		repeat (2) @(posedge core_clk);
		rd(FLAG_OFS, fw(1'b0, 1'b1, lvl));
		apb(1'b1, TRAP_OFS, 32'(SW_VEC_LIMIT - 1));
		repeat (2) @(posedge core_clk);
		rd(FLAG_OFS, fw(1'b0, 1'b0, lvl));
		rd(8'h0c, 32'h0);
		repeat (2) @(posedge core_clk);
		$display("test trap done");
		apb(1'b1, STATUS_OFS, 32'h0);
		rd(STATUS_OFS, 32'h0);
		apb(1'b1, FLAG_OFS, fw(1'b1, 1'b0, 3'h0));
		@(posedge core_clk) want <= '{1'b1, 3'h1, 1'b0};
		@(posedge core_clk) #1;
		`CHK("irqAccept", 1'b1, irqAccept)
		rd(STATUS_OFS, 32'h3);
		// A clear that meets a new accept must lose to it.
		apb(1'b1, STATUS_OFS, 32'h0);
		rd(STATUS_OFS, 32'h3);
		@(posedge core_clk) want <= '0;
		repeat (2) @(posedge core_clk);
		rd(STATUS_OFS, 32'h1);
		apb(1'b1, STATUS_OFS, 32'h0);
		rd(STATUS_OFS, 32'h0);
		$display("test status done");
		apb(1'b1, FLAG_OFS, fw(1'b1, 1'b1, lvl));
		@(posedge core_clk)
		begin
			nrst <= 1'b0;
			want <= '{1'b1, 3'h7, 1'b0};
		end
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("irqAccept", 1'b0, irqAccept)
		`CHK("useUserStack", 1'b0, useUserStack)
		rd(FLAG_OFS, 32'h0);
		@(posedge core_clk) want <= '0;
		$display("test reset done");
		wrap_up();
	end
endmodule : tb
